// ===== hw/prbs_bist.sv
// test packet generator and pseudo-random sequence checker with registers
// How it works
// - packet overflow flag at status bit 10, held until counters cleared
// - byte overflow flag at status bit 9, held until counters cleared
// - writing one to status bit 1 clears both overflow flags
// - eight-bit error byte count sits in status bits 7:0
// - in saturate mode the error count stops at 0xFF
// - writing status bit 0 locks the visible counter values
// - writing status bit 1 locks the counters then zeroes them
// - packet payload length in bytes from 16-bit register, reset 1500
// - each packet starts with 13 nibbles of 0x5 then byte 0xD5
// - idle gap between packets set by eight-bit gap field
// - each gap unit adds four bytes; reset value gives 500 bytes
// - 16-bit received byte count, locked, saturating at 0xFFFF in mode 0
`timescale 1ns/1ns
`include "prbs_bist_map.svh"
module prbs_bist (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [15:0] reg_rdata_o,
  // generated nibble stream
  output logic             tx_valid_o,
  output logic      [3:0]  tx_nibble_o,
  // received byte stream
  input  wire logic        rx_valid_i,
  input  wire logic        rx_sop_i,
  input  wire logic        rx_eop_i,
  input  wire logic [7:0]  rx_data_i,
  // interrupt
  output logic             irq_o
);

  // -------------------------------------------------------------------------
  // registers and address decode
  // -------------------------------------------------------------------------
  prbs_bist_pkg::reg_word_t control;
  prbs_bist_pkg::reg_word_t generated_packet_length;
  logic [7:0]               gap_length_units;
  logic [`EVT_WIDTH-1:0]    event_status;
  logic [`EVT_WIDTH-1:0]    event_mask;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  wire wr_control  = reg_write_i && hit(reg_addr_i, `OFS_TEST_CONTROL_MAIN);
  wire wr_status2  = reg_write_i &&
                     hit(reg_addr_i, `OFS_TEST_CHECKER_STATUS_TWO);
  wire wr_length   = reg_write_i && hit(reg_addr_i, `OFS_TEST_PACKET_LENGTH);
  wire wr_gap      = reg_write_i && hit(reg_addr_i, `OFS_TEST_GAP_LENGTH);
  wire wr_evstat   = reg_write_i && hit(reg_addr_i, `OFS_EVENT_STATUS);
  wire wr_evmask   = reg_write_i && hit(reg_addr_i, `OFS_EVENT_MASK);
  wire lock_pulse  = wr_status2 && reg_wdata_i[`BIT_LOCK];
  wire clear_pulse = wr_status2 && reg_wdata_i[`BIT_LOCK_CLEAR];
  wire gen_enable  = control[`BIT_GEN_ENABLE];
  wire chk_enable  = control[`BIT_CHECK_ENABLE];
  wire wrap_mode   = control[`BIT_COUNTER_WRAP_MODE];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control                 <= `RST_TEST_CONTROL_MAIN;
      generated_packet_length <= `RST_TEST_PACKET_LENGTH;
      gap_length_units        <= `RST_GAP_LENGTH_UNITS;
      event_mask              <= '0;
    end else begin
      if (wr_control) begin
        control <= reg_wdata_i;
      end
      if (wr_length) begin
        generated_packet_length <= reg_wdata_i;
      end
      if (wr_gap) begin
        gap_length_units <= reg_wdata_i[7:0];
      end
      if (wr_evmask) begin
        event_mask <= reg_wdata_i[`EVT_WIDTH-1:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // packet generator
  // -------------------------------------------------------------------------
  prbs_step_if gen_step ();
  prbs_step_if chk_step ();

  prbs_byte_source gen_source (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .step   (gen_step)
  );

  prbs_bist_pkg::gen_state_e gen_state;
  prbs_bist_pkg::gen_state_e next_gen_state;
  logic [17:0]               nib_cnt;
  logic [17:0]               next_nib_cnt;
  logic [3:0]                next_nibble;
  logic                      next_valid;
  logic                      packet_sent;

  // lengths counted in nibbles, two per byte
  wire [17:0] payload_nibbles = {1'b0, generated_packet_length, 1'b0};
  wire [17:0] gap_nibbles     =
    18'({gap_length_units, 3'b000});
  // a length cut below the nibbles already sent lets the count run round
  wire        last_nib        = (nib_cnt == payload_nibbles - 18'h1);
  wire [3:0]  sfd_low         = 4'(`SFD_BYTE);
  wire [3:0]  sfd_high        = 4'(`SFD_BYTE >> 4);

  always_comb begin
    next_gen_state   = gen_state;
    next_nib_cnt     = nib_cnt + 18'h1;
    next_nibble      = 4'h0;
    next_valid       = 1'b0;
    packet_sent      = 1'b0;
    gen_step.restart = 1'b0;
    gen_step.advance = 1'b0;
    case (gen_state)
      prbs_bist_pkg::GEN_IDLE: begin
        next_nib_cnt = '0;
        if (gen_enable) begin
          next_gen_state = prbs_bist_pkg::GEN_PREAMBLE;
        end
      end
      prbs_bist_pkg::GEN_PREAMBLE: begin
        next_nibble = `PREAMBLE_NIBBLE;
        next_valid  = 1'b1;
        if (nib_cnt == `PREAMBLE_NIBBLES - 18'h1) begin
          next_gen_state = prbs_bist_pkg::GEN_SFD;
          next_nib_cnt   = '0;
        end
      end
      prbs_bist_pkg::GEN_SFD: begin
        // low nibble first, as on a nibble-wide media interface
        next_nibble      = nib_cnt[0] ? sfd_high : sfd_low;
        next_valid       = 1'b1;
        gen_step.restart = 1'b1;
        if (nib_cnt[0]) begin
          next_nib_cnt   = '0;
          next_gen_state = (payload_nibbles == '0) ?
                           prbs_bist_pkg::GEN_GAP :
                           prbs_bist_pkg::GEN_PAYLOAD;
        end
      end
      prbs_bist_pkg::GEN_PAYLOAD: begin
        next_nibble      = nib_cnt[0] ? gen_step.value[7:4] :
                                        gen_step.value[3:0];
        next_valid       = 1'b1;
        gen_step.advance = nib_cnt[0];
        if (last_nib) begin
          next_nib_cnt   = '0;
          packet_sent    = 1'b1;
          next_gen_state = prbs_bist_pkg::GEN_GAP;
        end
      end
      prbs_bist_pkg::GEN_GAP: begin
        if (nib_cnt >= gap_nibbles) begin
          next_nib_cnt   = '0;
          next_gen_state = gen_enable ? prbs_bist_pkg::GEN_PREAMBLE :
                                        prbs_bist_pkg::GEN_IDLE;
        end
      end
      default: begin
        next_gen_state = prbs_bist_pkg::GEN_IDLE;
        next_nib_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gen_state   <= prbs_bist_pkg::GEN_IDLE;
      nib_cnt     <= '0;
      tx_valid_o  <= 1'b0;
      tx_nibble_o <= 4'h0;
    end else begin
      gen_state   <= next_gen_state;
      nib_cnt     <= next_nib_cnt;
      tx_valid_o  <= next_valid;
      tx_nibble_o <= next_nibble;
    end
  end

  // -------------------------------------------------------------------------
  // sequence checker
  // -------------------------------------------------------------------------
  prbs_byte_source chk_source (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .step   (chk_step)
  );

  wire       rx_take  = chk_enable && rx_valid_i;
  // the expected sequence restarts at every packet's first byte
  wire [7:0] expected = rx_sop_i ? 8'(`PRBS_SEED) : chk_step.value;
  wire       mismatch = rx_take && (rx_data_i != expected);
  wire       pkt_end  = rx_take && rx_eop_i;

  assign chk_step.restart = rx_take && rx_sop_i;
  assign chk_step.advance = rx_take;

  logic [15:0] byte_live;
  logic [7:0]  err_live;
  logic [15:0] pkt_live;
  logic [15:0] byte_seen;
  logic [7:0]  err_seen;
  logic [15:0] pkt_seen;
  logic        byte_ovf;
  logic        pkt_ovf;

  wire byte_full = &byte_live;
  wire err_full  = &err_live;
  wire pkt_full  = &pkt_live;
  wire byte_wrap = rx_take && byte_full;
  wire pkt_wrap  = pkt_end && pkt_full;

  // a clear restarts from zero, so a byte in the same cycle still counts
  wire [15:0] byte_base = clear_pulse ? 16'h0000 : byte_live;
  wire [7:0]  err_base  = clear_pulse ? 8'h00 : err_live;
  wire [15:0] pkt_base  = clear_pulse ? 16'h0000 : pkt_live;
  wire byte_step = rx_take && (clear_pulse || wrap_mode || !byte_full);
  wire err_step  = mismatch && (clear_pulse || wrap_mode || !err_full);
  wire pkt_step  = pkt_end && (clear_pulse || wrap_mode || !pkt_full);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte_live <= '0;
    end else begin
      byte_live <= byte_base + {15'h0000, byte_step};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_live <= '0;
    end else begin
      err_live <= err_base + {7'h00, err_step};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pkt_live <= '0;
    end else begin
      pkt_live <= pkt_base + {15'h0000, pkt_step};
    end
  end

  // a wrap in the very cycle of a clear still leaves its flag set, so
  // software never loses an overflow that raced its own clear
  wire byte_ovf_keep = byte_ovf && !clear_pulse;
  wire pkt_ovf_keep  = pkt_ovf && !clear_pulse;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte_ovf <= 1'b0;
      pkt_ovf  <= 1'b0;
    end else begin
      byte_ovf <= byte_ovf_keep | byte_wrap;
      pkt_ovf  <= pkt_ovf_keep | pkt_wrap;
    end
  end

  // software sees a snapshot so multi-register reads stay coherent
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte_seen <= '0;
      err_seen  <= '0;
      pkt_seen  <= '0;
    end else if (lock_pulse || clear_pulse) begin
      byte_seen <= byte_live;
      err_seen  <= err_live;
      pkt_seen  <= pkt_live;
    end
  end

  // -------------------------------------------------------------------------
  // events and interrupt
  // -------------------------------------------------------------------------
  logic [`EVT_WIDTH-1:0] evt_raw;

  always_comb begin
    evt_raw                       = '0;
    evt_raw[`EVT_BYTE_OVERFLOW]   = byte_wrap;
    evt_raw[`EVT_PACKET_OVERFLOW] = pkt_wrap;
    evt_raw[`EVT_ERROR_BYTE]      = mismatch;
    evt_raw[`EVT_PACKET_SENT]     = packet_sent;
  end

  wire [`EVT_WIDTH-1:0] evt_clear =
    wr_evstat ? reg_wdata_i[`EVT_WIDTH-1:0] : '0;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      event_status <= '0;
    end else begin
      // a new event outranks a clear in the same cycle
      event_status <= (event_status & ~evt_clear) | evt_raw;
    end
  end

  assign irq_o = |(event_status & event_mask);

  // -------------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------------
  logic [15:0] read_mux;

  always_comb begin
    read_mux = 16'h0000;
    case (reg_addr_i)
      `OFS_TEST_CONTROL_MAIN:       read_mux = control;
      `OFS_RECEIVED_BYTE_COUNT:     read_mux = byte_seen;
      `OFS_TEST_CHECKER_STATUS_TWO: begin
        read_mux                       = {8'h00, err_seen};
        read_mux[`BIT_BYTE_OVERFLOW]   = byte_ovf;
        read_mux[`BIT_PACKET_OVERFLOW] = pkt_ovf;
      end
      `OFS_RECEIVED_PACKET_COUNT:   read_mux = pkt_seen;
      `OFS_TEST_PACKET_LENGTH:      read_mux = generated_packet_length;
      `OFS_TEST_GAP_LENGTH:         read_mux = {8'h00, gap_length_units};
      `OFS_EVENT_STATUS:            read_mux = 16'(event_status);
      `OFS_EVENT_MASK:              read_mux = 16'(event_mask);
      default:                      read_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_read_i) begin
      reg_rdata_o <= read_mux;
    end
  end

endmodule

// ===== hw/prbs_bist_map.svh
// register offsets, field positions, reset values and constants of the test block
`ifndef PRBS_BIST_MAP_SVH
`define PRBS_BIST_MAP_SVH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define OFS_TEST_CONTROL_MAIN        8'h16
`define OFS_RECEIVED_BYTE_COUNT      8'h71
`define OFS_TEST_CHECKER_STATUS_TWO  8'h72
`define OFS_RECEIVED_PACKET_COUNT    8'h73
`define OFS_TEST_PACKET_LENGTH       8'h7B
`define OFS_TEST_GAP_LENGTH          8'h7C
`define OFS_EVENT_STATUS             8'h80
`define OFS_EVENT_MASK               8'h81

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define BIT_GEN_ENABLE               0
`define BIT_CHECK_ENABLE             1
`define BIT_COUNTER_WRAP_MODE        2
`define BIT_LOCK                     0
`define BIT_LOCK_CLEAR               1
`define BIT_BYTE_OVERFLOW            9
`define BIT_PACKET_OVERFLOW          10
`define EVT_BYTE_OVERFLOW            0
`define EVT_PACKET_OVERFLOW          1
`define EVT_ERROR_BYTE               2
`define EVT_PACKET_SENT              3
`define EVT_WIDTH                    4

// ---------------------------------------------------------------------------
// reset values and sequence constants
// ---------------------------------------------------------------------------
`define RST_TEST_PACKET_LENGTH       16'h05DC
`define RST_GAP_LENGTH_UNITS         8'h7D
`define RST_TEST_CONTROL_MAIN        16'h0000
`define PREAMBLE_NIBBLES             18'h0000D
`define PREAMBLE_NIBBLE              4'h5
`define SFD_BYTE                     8'hD5
`define GAP_BYTES_PER_UNIT           4
`define PRBS_SEED                    15'h7FFF

`endif

// ===== hw/prbs_bist_pkg.sv
// types shared by the test packet generator and checker
package prbs_bist_pkg;

  typedef enum logic [2:0] {
    GEN_IDLE,
    GEN_PREAMBLE,
    GEN_SFD,
    GEN_PAYLOAD,
    GEN_GAP
  } gen_state_e;

  typedef logic [15:0] reg_word_t;

endpackage

// ===== hw/prbs_step_if.sv
// handshake between a pseudo-random byte source and its user
`timescale 1ns/1ns
interface prbs_step_if;
  logic       restart;
  logic       advance;
  logic [7:0] value;

  modport source (
    input  restart,
    input  advance,
    output value
  );
  modport user (
    output restart,
    output advance,
    input  value
  );
endinterface

// ===== hw/prbs_byte_source.sv
// pseudo-random byte source, x^15 + x^14 + 1, eight steps per byte
`timescale 1ns/1ns
`include "prbs_bist_map.svh"
module prbs_byte_source (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  // sequence port
  prbs_step_if.source step
);

  logic [14:0] state;
  logic [14:0] base;
  logic [14:0] next_state;

  function automatic logic [14:0] step8(input logic [14:0] s);
    logic [14:0] t;
    t = s;
    for (int i = 0; i < 8; i++) begin
      t = {t[13:0], t[14] ^ t[13]};
    end
    return t;
  endfunction

  // a restart that also advances lets the first byte be used in place
  assign base       = step.restart ? `PRBS_SEED : state;
  assign next_state = step.advance ? step8(base) : base;
  assign step.value = state[7:0];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= `PRBS_SEED;
    end else begin
      state <= next_state;
    end
  end

endmodule

// ===== sim/prbs_loopback.sv
// far side model: turns the nibble stream back into checker bytes
`timescale 1ns/1ns
module prbs_loopback (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // stream from the generator
  input  wire logic       tx_valid_i,
  input  wire logic [3:0] tx_nibble_i,
  input  wire logic       corrupt_i,
  // bytes to the checker
  output logic            rx_valid_o,
  output logic            rx_sop_o,
  output logic            rx_eop_o,
  output logic      [7:0] rx_data_o
);
  logic [17:0] n;
  logic [3:0]  low;
  logic [7:0]  held;
  logic [7:0]  byte_q;
  logic        have;
  logic        first;
  logic        prev;

  // one byte is held back so that the last one can carry eop
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {n, low, held, byte_q, have, prev} <= '0;
      {rx_valid_o, rx_sop_o, rx_eop_o} <= 3'h0;
      first <= 1'b1;
    end else begin
      {rx_valid_o, rx_sop_o, rx_eop_o} <= 3'h0;
      prev <= tx_valid_i;
      if (tx_valid_i) begin
        n <= n + 18'h00001;
        if (n >= 18'h0000F && n[0]) low <= tx_nibble_i;
        if (n >= 18'h00010 && !n[0]) begin
          if (have) begin
            {rx_valid_o, rx_sop_o, byte_q} <= {1'b1, first, held};
            first <= 1'b0;
          end
          held <= {tx_nibble_i, low};
          have <= 1'b1;
        end
      end else begin
        n <= '0;
        if (prev && have) begin
          {rx_valid_o, rx_sop_o, rx_eop_o, byte_q} <= {1'b1, first, 1'b1, held};
        end
        have <= 1'b0;
        first <= 1'b1;
      end
    end
  end

  // outside a byte the data lines never show the last value
  assign rx_data_o = rx_valid_o ? byte_q ^ {7'h00, corrupt_i} : ~byte_q;
endmodule

// ===== sim/prbs_bist_props.sv
// port-level checker of the test packet generator and checker
`timescale 1ns/1ns
`include "prbs_bist_map.svh"
module prbs_bist_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_write_i,
  input wire logic        reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  // streams and interrupt
  input wire logic        tx_valid_o,
  input wire logic [3:0]  tx_nibble_o,
  input wire logic        rx_valid_i,
  input wire logic        rx_sop_i,
  input wire logic        rx_eop_i,
  input wire logic [7:0]  rx_data_i,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [15:0] len_q;
  logic [7:0]  gap_q;
  logic [17:0] on_cnt;
  logic [11:0] idle_cnt;
  logic        prev_v;
  logic        seen_fall;
  wire         wr72 = reg_write_i && reg_addr_i == 8'h72;
  wire         mapped = reg_addr_i inside {`OFS_TEST_CONTROL_MAIN,
    `OFS_RECEIVED_BYTE_COUNT, `OFS_TEST_CHECKER_STATUS_TWO,
    `OFS_RECEIVED_PACKET_COUNT, `OFS_TEST_PACKET_LENGTH,
    `OFS_TEST_GAP_LENGTH, `OFS_EVENT_STATUS, `OFS_EVENT_MASK};

  // -------
  // shadow of length and gap, run lengths of the stream
  // -------
  // a control write restarts gap tracking: a re-enable gap is not timed
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {len_q, gap_q} <= {16'h05DC, 8'h7D};
      {on_cnt, idle_cnt, prev_v, seen_fall} <= '0;
    end else begin
      if (reg_write_i && reg_addr_i == 8'h7B) len_q <= reg_wdata_i;
      if (reg_write_i && reg_addr_i == 8'h7C) gap_q <= reg_wdata_i[7:0];
      on_cnt <= tx_valid_o ? on_cnt + 18'h00001 : 18'h00000;
      idle_cnt <= tx_valid_o ? 12'h000 : idle_cnt + 12'h001;
      prev_v <= tx_valid_o;
      if (reg_write_i && reg_addr_i == 8'h16) seen_fall <= 1'b0;
      else if (prev_v && !tx_valid_o) seen_fall <= 1'b1;
    end
  end

  // -------
  // properties
  // -------
  a_preamble_run: assert property ($rose(tx_valid_o) |->
    (tx_nibble_o == 4'h5) [*8] ##1 (tx_nibble_o == 4'h5) [*6]
    ##1 tx_nibble_o == 4'hD) else $error("preamble or sfd wrong");
  a_packet_length: assert property ($fell(tx_valid_o) |->
    on_cnt == {1'b0, len_q, 1'b0} + 18'h0000F)
    else $error("packet length wrong");
  a_gap_length: assert property ($rose(tx_valid_o) && seen_fall |->
    idle_cnt == {1'b0, gap_q, 3'h0} + 12'h001) else $error("gap wrong");
  a_status_reserved: assert property (
    reg_read_i && reg_addr_i == 8'h72 |=> (reg_rdata_o & 16'hF900) == 0)
    else $error("reserved status bits set");
  a_clear_flags: assert property (wr72 && reg_wdata_i[1]
    && !rx_valid_i ##[1:2]
    reg_read_i && reg_addr_i == 8'h72 |=> reg_rdata_o[10:9] == 2'h0)
    else $error("overflow flags survive clear");
  a_length_readback: assert property (
    reg_read_i && reg_addr_i == 8'h7B |=> reg_rdata_o == $past(len_q))
    else $error("length readback wrong");
  a_gap_readback: assert property (
    reg_read_i && reg_addr_i == 8'h7C |=> reg_rdata_o == {8'h00, $past(gap_q)})
    else $error("gap readback wrong");
  a_unmapped_zero: assert property (
    reg_read_i && !mapped |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind prbs_bist prbs_bist_props i_props (.clk_i(clk_i), .rstn_i(rstn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .tx_valid_o(tx_valid_o),
  .tx_nibble_o(tx_nibble_o), .rx_valid_i(rx_valid_i), .rx_sop_i(rx_sop_i),
  .rx_eop_i(rx_eop_i), .rx_data_i(rx_data_i), .irq_o(irq_o));

// ===== sim/prbs_bist_tb.sv
// self-checking bench for the test packet generator and checker
`timescale 1ns/1ns
module prbs_bist_tb;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i = 1'b0;
  logic        corrupt = 1'b0;
  logic [15:0] reg_rdata_o;
  logic        tx_valid_o;
  logic [3:0]  tx_nibble_o;
  logic        rx_valid_i;
  logic        rx_sop_i;
  logic        rx_eop_i;
  logic [7:0]  rx_data_i;
  logic        irq_o;
  logic [15:0] n_bytes = 16'h0000;
  logic [15:0] n_pkts = 16'h0000;
  logic [15:0] n_errs = 16'h0000;
  logic [15:0] base_bytes = 16'h0000;
  logic [15:0] base_pkts = 16'h0000;
  logic [15:0] base_errs = 16'h0000;
  int          fail_count = 0;
  int          checked = 0;

  always #25 clk_i = ~clk_i;

  prbs_bist i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .tx_valid_o(tx_valid_o), .tx_nibble_o(tx_nibble_o),
    .rx_valid_i(rx_valid_i), .rx_sop_i(rx_sop_i), .rx_eop_i(rx_eop_i),
    .rx_data_i(rx_data_i), .irq_o(irq_o));
  prbs_loopback i_far (.clk_i(clk_i), .rstn_i(rstn_i),
    .tx_valid_i(tx_valid_o), .tx_nibble_i(tx_nibble_o), .corrupt_i(corrupt),
    .rx_valid_o(rx_valid_i), .rx_sop_o(rx_sop_i), .rx_eop_o(rx_eop_i),
    .rx_data_o(rx_data_i));

  // expected counts come from what the far side really sent
  always @(posedge clk_i) begin
    if (rx_valid_i === 1'b1) begin
      n_bytes <= n_bytes + 16'h0001;
      n_errs <= n_errs + {15'h0000, corrupt};
      n_pkts <= n_pkts + {15'h0000, rx_eop_i};
    end
  end

  // -------
  // access tasks
  // -------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // strobes rise on one edge and fall on the next, so calls in a row
  // leave one idle cycle and never touch a strobe twice in a time step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {reg_addr_i, reg_wdata_i, reg_write_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    {reg_addr_i, reg_read_i} <= {a, 1'b1};
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    @(negedge clk_i);
    chk(reg_rdata_o, exp);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a wait that runs out ends the run as a mismatch
  task automatic wait_tx(input logic v, input int n);
    for (int i = 0; i < n && tx_valid_o !== v; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (tx_valid_o !== v) begin
      fail_count++;
      summarize();
    end
  endtask

  // -------
  // tests
  // -------
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(8'h7B, 16'h05DC);
    rd(8'h7C, 16'h007D);
    rd(8'h72, 16'h0000);
    rd(8'h55, 16'h0000);
    wr(8'h7C, 16'hFF7D);
    rd(8'h7C, 16'h007D);
    // default packet with every byte spoiled, saturate mode
    wr(8'h16, 16'h0003);
    corrupt <= 1'b1;
    wait_tx(1'b1, 10);
    wait_tx(1'b0, 4000);
    wr(8'h16, 16'h0002);
    corrupt <= 1'b0;
    repeat (1100) @(posedge clk_i);
    wr(8'h72, 16'h0001);
    rd(8'h71, 16'h05DC);
    rd(8'h73, 16'h0001);
    rd(8'h72, 16'h00FF);
    rd(8'h80, 16'h000C);
    chk({15'h0000, irq_o}, 16'h0000);
    wr(8'h81, 16'h0004);
    @(negedge clk_i);
    chk({15'h0000, irq_o}, 16'h0001);
    wr(8'h80, 16'h000C);
    @(negedge clk_i);
    chk({15'h0000, irq_o}, 16'h0000);
    wr(8'h72, 16'h0002);
    rd(8'h72, 16'h00FF);
    wr(8'h72, 16'h0001);
    rd(8'h72, 16'h0000);
    rd(8'h71, 16'h0000);
    $display("test 1 done");
    // short packets, tight gap, wrap mode, enough spoiled bytes to wrap
    // the error count past 0xFF
    wr(8'h7B, 16'h0004);
    wr(8'h7C, 16'h0001);
    rd(8'h7B, 16'h0004);
    base_bytes = n_bytes;
    base_pkts = n_pkts;
    base_errs = n_errs;
    wr(8'h16, 16'h0007);
    repeat (70) @(posedge clk_i);
    corrupt <= 1'b1;
    repeat (2100) @(posedge clk_i);
    corrupt <= 1'b0;
    repeat (90) @(posedge clk_i);
    wr(8'h16, 16'h0006);
    repeat (60) @(posedge clk_i);
    wr(8'h72, 16'h0001);
    rd(8'h71, n_bytes - base_bytes);
    rd(8'h73, n_pkts - base_pkts);
    rd(8'h72, {8'h00, 8'(n_errs - base_errs)});
    chk({15'h0000, irq_o}, 16'h0001);
    $display("test 2 done");
    summarize();
  end
endmodule
